// ---- lam_pkg.sv ----
/*
 * lam_pkg: constants and types shared by the target-side address match
 * and register pointer front end.
 * Assumes a single 100 MHz system clock and an active-low async reset.
 */
package lam_pkg;

  localparam int unsigned LAM_CLK_MHZ = 100;

  // receive / transmit byte sequencer states
  typedef enum logic [2:0] {
    LAM_ST_IDLE,
    LAM_ST_RX,
    LAM_ST_ACK,
    LAM_ST_TX,
    LAM_ST_TX_ACK,
    LAM_ST_RD_WAIT
  } lam_state_t;

  // which byte of the transfer is being received
  typedef enum logic [1:0] {
    LAM_PH_ADDR,
    LAM_PH_CTRL,
    LAM_PH_DATA,
    LAM_PH_DONE
  } lam_phase_t;

  localparam logic [3:0] LAM_BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAM_LAST_TX_BIT = 4'h7;

  // fixed call address, write direction only
  localparam logic [7:0] LAM_SOFT_RESET_CALL = 8'h06;

  // reset values
  localparam logic [7:0] LAM_BCAST_RST = 8'he0;
  localparam logic [7:0] LAM_GRP1_RST = 8'he2;
  localparam logic [7:0] LAM_GRP2_RST = 8'he4;
  localparam logic [7:0] LAM_GRP3_RST = 8'he8;
  localparam logic [7:0] LAM_CTRL_RST = 8'h80;
  // mode_reg_one low bits: sleep=1, group enables off, broadcast on
  localparam logic [4:0] LAM_MODE_REG_ONE_RST = 5'h11;

  // mode_reg_one field positions
  localparam int unsigned LAM_M1_BCAST_EN = 0;
  localparam int unsigned LAM_M1_GRP3_EN = 1;
  localparam int unsigned LAM_M1_GRP2_EN = 2;
  localparam int unsigned LAM_M1_GRP1_EN = 3;
  localparam int unsigned LAM_M1_SLEEP = 4;

  // register pointer values
  localparam logic [4:0] LAM_PTR_MODE_REG_ONE = 5'h00;
  localparam logic [4:0] LAM_PTR_GRP1 = 5'h18;
  localparam logic [4:0] LAM_PTR_GRP2 = 5'h19;
  localparam logic [4:0] LAM_PTR_GRP3 = 5'h1a;
  localparam logic [4:0] LAM_PTR_BCAST = 5'h1b;
  localparam logic [4:0] LAM_PTR_LAST = 5'h1b;
  localparam logic [4:0] LAM_PTR_FIRST = 5'h00;
  localparam logic [4:0] LAM_PTR_BRIGHT_FIRST = 5'h02;
  localparam logic [4:0] LAM_PTR_BRIGHT_LAST = 5'h11;
  localparam logic [4:0] LAM_PTR_GLOBAL_FIRST = 5'h12;
  localparam logic [4:0] LAM_PTR_GLOBAL_LAST = 5'h13;

  // increment option codes
  localparam logic [2:0] LAM_INC_ALL = 3'h4;
  localparam logic [2:0] LAM_INC_BRIGHT = 3'h5;
  localparam logic [2:0] LAM_INC_GLOBAL = 3'h6;
  localparam logic [2:0] LAM_INC_BRIGHT_GLOBAL = 3'h7;

endpackage : lam_pkg

// ---- lam_sync.sv ----
/*
 * lam_sync: two-flop synchroniser for a vector of slow or asynchronous pins.
 * Assumes each bit may change at any time relative to sys_clk_in.
 */
`timescale 1ns/1ps
module lam_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic sys_clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  input wire logic [WIDTH-1:0] rst_val_in, // constant idle level
  output logic [WIDTH-1:0] sync_out // synchronised levels
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // reset loads all ones whatever the idle level; rst_val_in does not change sync_out
  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= '1;
      sync_reg <= '1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg & (rst_val_in | ~rst_val_in);
endmodule : lam_sync

// ---- lam_ptr_step.sv ----
/*
 * lam_ptr_step: next value of the 5-bit register pointer after one access.
 * Assumes the caller only applies the result after a completed data byte.
 */
`timescale 1ns/1ps
module lam_ptr_step
  import lam_pkg::*;
(
  input wire logic [4:0] ptr_in, // current pointer
  input wire logic [2:0] opt_in, // increment option field
  output logic [4:0] ptr_out // pointer for the next access
);
  logic [4:0] range_end;
  logic [4:0] range_start;

  always_comb
  begin
    range_end = LAM_PTR_LAST;
    range_start = LAM_PTR_FIRST;
    unique case (opt_in)
      LAM_INC_BRIGHT:
      begin
        range_end = LAM_PTR_BRIGHT_LAST;
        range_start = LAM_PTR_BRIGHT_FIRST;
      end
      LAM_INC_GLOBAL:
      begin
        range_end = LAM_PTR_GLOBAL_LAST;
        range_start = LAM_PTR_GLOBAL_FIRST;
      end
      LAM_INC_BRIGHT_GLOBAL:
      begin
        range_end = LAM_PTR_GLOBAL_LAST;
        range_start = LAM_PTR_BRIGHT_FIRST;
      end
      default:
      begin
        range_end = LAM_PTR_LAST;
        range_start = LAM_PTR_FIRST;
      end
    endcase
    // flag clear (incl. reserved codes): pointer stays put
    if (!opt_in[2])
      ptr_out = ptr_in;
    else if (ptr_in == range_end)
      ptr_out = range_start;
    else if (ptr_in == LAM_PTR_LAST)
      ptr_out = LAM_PTR_FIRST;
    else
      ptr_out = ptr_in + 5'h01;
  end
endmodule : lam_ptr_step

// ---- lam_addr_ptr.sv ----
/*
 * lam_addr_ptr: target-side serial bus front end. Decides which address
 * bytes to acknowledge, captures the control byte, advances the register
 * pointer and holds the address-match registers and mode_reg_one enables.
 * Assumes SCL/SDA arrive unsynchronised, SDA is open drain resolved by the
 * board, and the other registers live outside behind the ext_* ports.
 */
`timescale 1ns/1ps

module lam_addr_ptr
  import lam_pkg::*;
(
  input wire logic sys_clk_in, // 100 MHz system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic scl_in, // serial clock pin level
  input wire logic sda_in, // serial data pin level
  output logic sda_out, // data drive level, always low
  output logic sda_oe_n_out, // low while pulling data low
  input wire logic [6:0] hw_addr_in, // hardware address pins
  input wire logic [7:0] ext_rd_data_in, // data of external register at ptr_out
  output logic [4:0] ptr_out, // current register pointer
  output logic [2:0] increment_option_out, // stored increment option
  output logic ext_wr_out, // one-cycle write strobe, external regs
  output logic [4:0] ext_wr_addr_out, // pointer of that write
  output logic [7:0] ext_wr_data_out, // data of that write
  output logic soft_reset_out, // one-cycle pulse on acknowledged call
  output logic sleep_out // mode_reg_one sleep bit
);
  logic [8:0] pin_sync;
  logic scl_s;
  logic sda_s;
  logic [6:0] hw_addr_s;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  lam_sync #(
    .WIDTH(9)
  ) u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .async_in({scl_in, sda_in, hw_addr_in}),
    .rst_val_in(9'h1ff),
    .sync_out(pin_sync)
  );

  assign scl_s = pin_sync[8];
  assign sda_s = pin_sync[7];
  assign hw_addr_s = pin_sync[6:0];

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end
    else
    begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  assign bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  lam_state_t state_reg, state_next;
  lam_phase_t phase_reg, phase_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic [7:0] tx_reg, tx_next;
  logic rd_reg, rd_next;
  logic oe_n_reg, oe_n_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [4:0] mode_reg_one_reg, mode_reg_one_next;
  logic [7:0] grp_reg [3];
  logic [7:0] grp_next [3];
  logic [7:0] bcast_reg, bcast_next;
  logic ext_wr_reg, ext_wr_next;
  logic [4:0] ext_addr_reg, ext_addr_next;
  logic [7:0] ext_data_reg, ext_data_next;
  logic srst_reg, srst_next;
  logic [4:0] ptr_adv;
  logic [7:0] rd_byte;
  logic addr_match;
  logic [2:0] grp_en;

  lam_ptr_step u_ptr_step (
    .ptr_in(ctrl_reg[4:0]),
    .opt_in(ctrl_reg[7:5]),
    .ptr_out(ptr_adv)
  );

  assign grp_en = {mode_reg_one_reg[LAM_M1_GRP1_EN], mode_reg_one_reg[LAM_M1_GRP2_EN],
                   mode_reg_one_reg[LAM_M1_GRP3_EN]};

  // address byte decode; the direction bit takes no part here, only the reset call compare uses it
  always_comb
  begin
    addr_match = (shift_reg[7:1] == hw_addr_s);
    if (mode_reg_one_reg[LAM_M1_BCAST_EN] && shift_reg[7:1] == bcast_reg[7:1])
      addr_match = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      if (grp_en[2-i] && shift_reg[7:1] == grp_reg[i][7:1])
        addr_match = 1'b1;
    end
  end

  // read data: option bits show in mode_reg_one's top bits
  always_comb
  begin
    unique case (ctrl_reg[4:0])
      LAM_PTR_MODE_REG_ONE: rd_byte = {ctrl_reg[7:5], mode_reg_one_reg};
      LAM_PTR_GRP1: rd_byte = grp_reg[0];
      LAM_PTR_GRP2: rd_byte = grp_reg[1];
      LAM_PTR_GRP3: rd_byte = grp_reg[2];
      LAM_PTR_BCAST: rd_byte = bcast_reg;
      default: rd_byte = ext_rd_data_in;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    tx_next = tx_reg;
    rd_next = rd_reg;
    oe_n_next = oe_n_reg;
    ctrl_next = ctrl_reg;
    mode_reg_one_next = mode_reg_one_reg;
    grp_next = grp_reg;
    bcast_next = bcast_reg;
    ext_wr_next = 1'b0;
    ext_addr_next = ext_addr_reg;
    ext_data_next = ext_data_reg;
    srst_next = 1'b0;
    if (bus_start)
    begin
      // repeated start restarts the address phase but keeps the pointer
      state_next = LAM_ST_RX;
      phase_next = LAM_PH_ADDR;
      cnt_next = 4'h0;
      oe_n_next = 1'b1;
    end
    else if (bus_stop)
    begin
      state_next = LAM_ST_IDLE;
      oe_n_next = 1'b1;
    end
    else
    begin
      unique case (state_reg)
        LAM_ST_IDLE:
        begin
          oe_n_next = 1'b1;
        end
        LAM_ST_RX:
        begin
          if (scl_rise && cnt_reg < LAM_BITS_PER_BYTE)
          begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next = cnt_reg + 4'h1;
          end
          else if (scl_fall && cnt_reg == LAM_BITS_PER_BYTE)
          begin
            state_next = LAM_ST_IDLE;
            unique case (phase_reg)
              LAM_PH_ADDR:
              begin
                if (shift_reg == LAM_SOFT_RESET_CALL)
                begin
                  // call checked first; read form falls through unanswered
                  state_next = LAM_ST_ACK;
                  oe_n_next = 1'b0;
                  phase_next = LAM_PH_DONE;
                  srst_next = 1'b1;
                end
                else if (addr_match)
                begin
                  state_next = LAM_ST_ACK;
                  oe_n_next = 1'b0;
                  rd_next = shift_reg[0];
                  phase_next = shift_reg[0] ? LAM_PH_DATA : LAM_PH_CTRL;
                end
              end
              LAM_PH_CTRL:
              begin
                if (shift_reg[4:0] <= LAM_PTR_LAST)
                begin
                  state_next = LAM_ST_ACK;
                  oe_n_next = 1'b0;
                  ctrl_next = shift_reg;
                  phase_next = LAM_PH_DATA;
                end
              end
              LAM_PH_DATA:
              begin
                state_next = LAM_ST_ACK;
                oe_n_next = 1'b0;
                unique case (ctrl_reg[4:0])
                  LAM_PTR_MODE_REG_ONE: mode_reg_one_next = shift_reg[4:0];
                  LAM_PTR_GRP1: grp_next[0] = shift_reg;
                  LAM_PTR_GRP2: grp_next[1] = shift_reg;
                  LAM_PTR_GRP3: grp_next[2] = shift_reg;
                  LAM_PTR_BCAST: bcast_next = shift_reg;
                  default:
                  begin
                    ext_wr_next = 1'b1;
                    ext_addr_next = ctrl_reg[4:0];
                    ext_data_next = shift_reg;
                  end
                endcase
                ctrl_next[4:0] = ptr_adv;
              end
              LAM_PH_DONE:
              begin
                state_next = LAM_ST_IDLE;
              end
            endcase
          end
        end
        LAM_ST_ACK:
        begin
          if (scl_fall)
          begin
            cnt_next = 4'h0;
            oe_n_next = 1'b1;
            if (phase_reg == LAM_PH_DONE)
              state_next = LAM_ST_IDLE;
            else if (rd_reg)
            begin
              state_next = LAM_ST_TX;
              tx_next = rd_byte;
              oe_n_next = rd_byte[7];
            end
            else
              state_next = LAM_ST_RX;
          end
        end
        LAM_ST_TX:
        begin
          if (scl_fall)
          begin
            if (cnt_reg == LAM_LAST_TX_BIT)
            begin
              oe_n_next = 1'b1;
              state_next = LAM_ST_TX_ACK;
            end
            else
            begin
              cnt_next = cnt_reg + 4'h1;
              tx_next = {tx_reg[6:0], 1'b0};
              oe_n_next = tx_reg[6];
            end
          end
        end
        LAM_ST_TX_ACK:
        begin
          if (scl_rise)
          begin
            // pointer advances after each byte read, acked or not
            ctrl_next[4:0] = ptr_adv;
            state_next = sda_s ? LAM_ST_IDLE : LAM_ST_RD_WAIT;
          end
        end
        LAM_ST_RD_WAIT:
        begin
          if (scl_fall)
          begin
            cnt_next = 4'h0;
            tx_next = rd_byte;
            oe_n_next = rd_byte[7];
            state_next = LAM_ST_TX;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= LAM_ST_IDLE;
      phase_reg <= LAM_PH_ADDR;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      rd_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      ctrl_reg <= LAM_CTRL_RST;
      mode_reg_one_reg <= LAM_MODE_REG_ONE_RST;
      grp_reg[0] <= LAM_GRP1_RST;
      grp_reg[1] <= LAM_GRP2_RST;
      grp_reg[2] <= LAM_GRP3_RST;
      bcast_reg <= LAM_BCAST_RST;
      ext_wr_reg <= 1'b0;
      ext_addr_reg <= 5'h00;
      ext_data_reg <= 8'h00;
      srst_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      tx_reg <= tx_next;
      rd_reg <= rd_next;
      oe_n_reg <= oe_n_next;
      ctrl_reg <= ctrl_next;
      mode_reg_one_reg <= mode_reg_one_next;
      grp_reg <= grp_next;
      bcast_reg <= bcast_next;
      ext_wr_reg <= ext_wr_next;
      ext_addr_reg <= ext_addr_next;
      ext_data_reg <= ext_data_next;
      srst_reg <= srst_next;
    end
  end

  // open drain: level is always low, only the enable moves
  assign sda_out = 1'b0;
  assign sda_oe_n_out = oe_n_reg;
  assign ptr_out = ctrl_reg[4:0];
  assign increment_option_out = ctrl_reg[7:5];
  assign ext_wr_out = ext_wr_reg;
  assign ext_wr_addr_out = ext_addr_reg;
  assign ext_wr_data_out = ext_data_reg;
  assign soft_reset_out = srst_reg;
  assign sleep_out = mode_reg_one_reg[LAM_M1_SLEEP];
endmodule : lam_addr_ptr

// ---- lam_addr_ptr_assertions.sv ----
/*
 * lam_addr_ptr_assertions: port-level checks for lam_addr_ptr.
 * Assumes it is bound to the design top, one clock domain.
 */
`timescale 1ns/1ps
module lam_addr_ptr_assertions (
  input wire logic sys_clk_in, // system clock
  input wire logic rst_n_in, // async reset, active low
  input wire logic scl_in, // bus clock pin
  input wire logic sda_oe_n_out, // data pull enable, low pulls
  input wire logic [4:0] ptr_out, // register pointer
  input wire logic [2:0] increment_option_out, // increment option
  input wire logic ext_wr_out, // external write strobe
  input wire logic [4:0] ext_wr_addr_out, // pointer of that write
  input wire logic soft_reset_out // reset call pulse
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // own rollover table, kept apart from the design's stepper
  function automatic logic [4:0] nxt(input logic [4:0] p, input logic [2:0] o);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = (o == 3'h6) ? 5'h12 : (o[0] ? 5'h02 : 5'h00);
    hi = (o == 3'h5) ? 5'h11 : (o[1] ? 5'h13 : 5'h1b);
    if (!o[2])
      return p;
    if (p == hi)
      return lo;
    if (p == 5'h1b)
      return 5'h00;
    return p + 5'h01;
  endfunction : nxt

  reset_state_a: assert property ($rose(rst_n_in) |-> sda_oe_n_out
    && ptr_out == 5'h00 && increment_option_out == 3'h4)
    else $error("state after reset wrong");
  ptr_range_a: assert property (ptr_out <= 5'h1b)
    else $error("pointer beyond last register");
  ptr_step_a: assert property (ext_wr_out |->
    ptr_out == nxt(ext_wr_addr_out, increment_option_out))
    else $error("pointer step wrong");
  fixed_ptr_a: assert property (ext_wr_out && increment_option_out == 3'h0 |->
    ptr_out == ext_wr_addr_out)
    else $error("pointer moved without increment");
  opt_keep_a: assert property (ext_wr_out |->
    increment_option_out == $past(increment_option_out))
    else $error("option bits changed by increment");
  wr_target_a: assert property (ext_wr_out |-> ext_wr_addr_out inside {[5'h01:5'h17]})
    else $error("external write to internal register");
  wr_pulse_a: assert property (ext_wr_out |=> (!ext_wr_out && $stable(ptr_out)) [*8])
    else $error("write strobe or pointer unsettled");
  soft_reset_call_pulse_a: assert property (soft_reset_out |=> !soft_reset_out [*8])
    else $error("reset call pulse too long");
  sda_edge_a: assert property (!$stable(sda_oe_n_out) |-> !scl_in)
    else $error("data changed while clock high");

  cover property (soft_reset_out);
  cover property (ext_wr_out && ext_wr_addr_out == 5'h11 && ptr_out == 5'h02);
  cover property (!sda_oe_n_out && scl_in);
endmodule : lam_addr_ptr_assertions

// ---- lam_bus_ctrl_model.sv ----
/*
 * lam_bus_ctrl_model: behavioural bus controller driving clock and data.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
`timescale 1ns/1ps
module lam_bus_ctrl_model (
  input wire logic sys_clk_in, // pacing clock
  input wire logic sda_in, // resolved data wire
  output logic scl_out, // bus clock, idle high
  output logic sda_out // low pulls data, high releases
);
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask : hold

  // also serves as repeated start
  task automatic start();
    sda_out = 1'b1;
    hold(10);
    scl_out = 1'b1;
    hold(10);
    sda_out = 1'b0;
    hold(10);
    scl_out = 1'b0;
    hold(2);
  endtask : start

  task automatic stop();
    sda_out = 1'b0;
    hold(10);
    scl_out = 1'b1;
    hold(10);
    sda_out = 1'b1;
    hold(10);
  endtask : stop

  // data moves two clocks after the fall so it never looks like start/stop
  task automatic bit_xfer(input logic b, output logic r);
    sda_out = b;
    hold(10);
    scl_out = 1'b1;
    hold(5);
    r = sda_in;
    hold(5);
    scl_out = 1'b0;
    hold(2);
  endtask : bit_xfer

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_xfer(d[i], r);
    bit_xfer(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask : rd_byte
endmodule : lam_bus_ctrl_model

// ---- lam_addr_ptr_tb.sv ----
/*
 * lam_addr_ptr_tb: self-checking bench for lam_addr_ptr.
 * Assumes the bus controller model and the bound checker.
 */
`timescale 1ns/1ps
module lam_addr_ptr_tb;
  // {ack expected, address byte}; last four after groups enabled
  localparam logic [8:0] TA [0:13] = '{9'h1e0, 9'h1e1, 9'h0e2, 9'h0e3, 9'h0e4, 9'h0e8,
    9'h0e9, 9'h106, 9'h007, 9'h0f0, 9'h1e2, 9'h1e5, 9'h1e8, 9'h0e0};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] hw = 7'h20;
  logic scl;
  logic m_sda;
  logic sda_w;
  logic sda_o;
  logic oe_n;
  logic [4:0] ptr;
  logic [2:0] opt;
  logic wr;
  logic [4:0] wr_a;
  logic [7:0] wr_d;
  logic [7:0] rd_d;
  logic swr;
  logic slp;
  logic [31:0] seed = 32'h0000005c;
  logic [7:0] mode_v = 8'h11;
  logic [12:0] expq [$];
  int num_errors = 0;
  int n_checks = 0;
  int n_srst = 0;

  always #5 sys_clk = ~sys_clk;
  // pull-up: high unless a party pulls low
  assign sda_w = m_sda & (oe_n | sda_o);
  assign rd_d = {3'h5, ptr};

  lam_bus_ctrl_model i_mst (
    .sys_clk_in(sys_clk),
    .sda_in(sda_w),
    .scl_out(scl),
    .sda_out(m_sda)
  );

  lam_addr_ptr i_dut (
    .sys_clk_in(sys_clk),
    .rst_n_in(rst_n),
    .scl_in(scl),
    .sda_in(sda_w),
    .sda_out(sda_o),
    .sda_oe_n_out(oe_n),
    .hw_addr_in(hw),
    .ext_rd_data_in(rd_d),
    .ptr_out(ptr),
    .increment_option_out(opt),
    .ext_wr_out(wr),
    .ext_wr_addr_out(wr_a),
    .ext_wr_data_out(wr_d),
    .soft_reset_out(swr),
    .sleep_out(slp)
  );

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  function automatic logic [4:0] nxt(input logic [4:0] p, input logic [2:0] o);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = (o == 3'h6) ? 5'h12 : (o[0] ? 5'h02 : 5'h00);
    hi = (o == 3'h5) ? 5'h11 : (o[1] ? 5'h13 : 5'h1b);
    if (!o[2])
      return p;
    if (p == hi)
      return lo;
    return (p == 5'h1b) ? 5'h00 : p + 5'h01;
  endfunction : nxt

  // readback: address registers hold defaults, others come from rd_d
  function automatic logic [7:0] rv(input logic [4:0] p);
    case (p)
      5'h18: return 8'he2;
      5'h19: return 8'he4;
      5'h1a: return 8'he8;
      5'h1b: return 8'he0;
      default: return {3'h5, p};
    endcase
  endfunction : rv

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic end_sim();
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic chk_addr(input logic [7:0] b, input logic e);
    logic k;
    logic [7:0] d;
    i_mst.start();
    i_mst.wr_byte(b, k);
    chk(13'(k), 13'(e));
    if (k && b[0])
      i_mst.rd_byte(1'b1, d);
    i_mst.stop();
  endtask : chk_addr

  // only documented option codes are sent
  task automatic wr_seq(input logic [6:0] a, input logic [7:0] c, input int n);
    logic k;
    logic [4:0] p;
    logic [7:0] d;
    i_mst.start();
    i_mst.wr_byte({a, 1'b0}, k);
    chk(13'(k), 13'h1);
    i_mst.wr_byte(c, k);
    chk(13'(k), 13'(c[4:0] <= 5'h1b));
    p = c[4:0];
    for (int i = 0; i < n && k; i++)
    begin
      d = (p == 5'h00) ? mode_v : ((p > 5'h17) ? rv(p) : rnd());
      if (p != 5'h00 && p < 5'h18)
        expq.push_back({p, d});
      i_mst.wr_byte(d, k);
      p = nxt(p, c[7:5]);
    end
    i_mst.stop();
    if (k)
      chk(13'({ptr, opt}), 13'({p, c[7:5]}));
  endtask : wr_seq

  task automatic rd_seq(input logic [7:0] c, input int n);
    logic k;
    logic [4:0] p;
    logic [7:0] d;
    wr_seq(hw, c, 0);
    i_mst.start();
    i_mst.wr_byte({hw, 1'b1}, k);
    chk(13'(k), 13'h1);
    p = c[4:0];
    for (int i = 0; i < n; i++)
    begin
      i_mst.rd_byte(i == n - 1, d);
      chk(13'(d), 13'(rv(p)));
      p = nxt(p, c[7:5]);
    end
    i_mst.stop();
    chk(13'(ptr), 13'(p));
  endtask : rd_seq

  always @(negedge sys_clk)
  begin
    if (wr === 1'b1)
      chk({wr_a, wr_d}, (expq.size() > 0) ? expq.pop_front() : 13'h0);
    // call pulses are counted here and compared once the address sweep is done
    if (swr === 1'b1)
      n_srst++;
  end

  initial
  begin
    repeat (100000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end

  initial
  begin
    logic [7:0] r;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    r = rnd();
    hw = {2'b01, r[4:0]}; // never the call or broadcast value
    chk({ptr, opt, oe_n, slp, 3'h0}, {5'h00, 3'h4, 1'b1, 1'b1, 3'h0});
    chk_addr({hw, 1'b0}, 1'b1);
    chk_addr({hw, 1'b1}, 1'b1);
    for (int i = 0; i < 10; i++)
      chk_addr(TA[i][7:0], TA[i][8]);
    chk(13'(n_srst), 13'h1);
    wr_seq(hw, 8'h1c, 1);
    wr_seq(hw, 8'h05, 3);
    wr_seq(7'h70, 8'h9a, 4);
    wr_seq(hw, 8'hb0, 3);
    wr_seq(hw, 8'hd3, 3);
    wr_seq(hw, 8'hf4, 30);
    rd_seq(8'h98, 4);
    rd_seq(8'hb0, 3);
    hw = 7'h7c;
    chk_addr(8'hf9, 1'b1);
    hw = {2'b01, r[4:0]};
    mode_v = 8'h0e;
    wr_seq(hw, 8'h00, 1);
    chk(13'(slp), 13'h0);
    for (int i = 10; i < 14; i++)
      chk_addr(TA[i][7:0], TA[i][8]);
    chk(13'(expq.size()), 13'h0);
    end_sim();
  end
endmodule : lam_addr_ptr_tb

bind lam_addr_ptr lam_addr_ptr_assertions i_chk (
  .sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in),
  .scl_in(scl_in),
  .sda_oe_n_out(sda_oe_n_out),
  .ptr_out(ptr_out),
  .increment_option_out(increment_option_out),
  .ext_wr_out(ext_wr_out),
  .ext_wr_addr_out(ext_wr_addr_out),
  .soft_reset_out(soft_reset_out)
);
